// file: fsa_defs.svh
`ifndef FSA_DEFS_SVH
`define FSA_DEFS_SVH
// status word fields
`define FSA_RP 7
`define FSA_QUAD 6
`define FSA_BP_HI 5
`define FSA_BP_LO 2
`define FSA_LATCH 1
`define FSA_BUSY 0
`define FSA_STATUS_RST 8'h00
`define FSA_BP_RST 4'h0
// instruction codes
`define FSA_SET_LATCH 8'h06
`define FSA_CLR_LATCH 8'h04
`define FSA_STAT_WR 8'h01
`define FSA_STAT_RD 8'h05
`define FSA_RDFR 8'h48
`define FSA_RDERP 8'h81
`define FSA_RST_EN 8'h66
`define FSA_RST 8'h99
`define FSA_SUSP_A 8'h75
`define FSA_SUSP_B 8'hb0
`define FSA_PP 8'h02
`define FSA_PPQ_A 8'h32
`define FSA_PPQ_B 8'h38
`define FSA_SER_A 8'hd7
`define FSA_SER_B 8'h20
`define FSA_BER32 8'h52
`define FSA_BER64 8'hd8
`define FSA_ARR_ERASE_A 8'hc7
`define FSA_ARR_ERASE_B 8'h60
`define FSA_WRFR 8'h42
`define FSA_SRPNV 8'h65
`define FSA_SERPNV 8'h85
`define FSA_IRER 8'h64
`define FSA_IRP 8'h62
`define FSA_WRABR 8'h15
// address map
`define FSA_TOP_MAX 24'h1fffff
`define FSA_TOP_MIN 24'h03ffff
`define FSA_DENS_MAX 2'h3
`define FSA_BLKS_MIN 6'h04
`define FSA_ADDR_MSB 20
`define FSA_SECT_LSB 12
`define FSA_B32_LSB 15
`define FSA_B64_LSB 16
// protect field decode
`define FSA_BP_ONE 4'h1
`define FSA_BP_TOP_END 4'h5
`define FSA_BP_ALL_LO 4'h6
`define FSA_BP_ALL_HI 4'h9
`define FSA_BP_BOT_LO 4'ha
`define FSA_BP_BOT_HI 4'he
`define FSA_SYNC_LEN 3
`endif

// file: fsa_pkg.sv
package fsa_pkg;
    typedef enum logic [2:0] {
        ST_READY = 3'b001,
        ST_ARRAY = 3'b010,
        ST_NVW = 3'b100
    } fsa_state_e;
    typedef enum logic [2:0] {
        OP_PAGE = 3'h0,
        OP_SECT = 3'h1,
        OP_BLK32 = 3'h2,
        OP_BLK64 = 3'h3,
        OP_CHIP = 3'h4,
        OP_STATUS = 3'h5,
        OP_NV_OTHER = 3'h6
    } fsa_op_e;
endpackage

// file: fsa_status.sv
`timescale 1ns/1ns
`include "fsa_defs.svh"
module fsa_status (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // decoded instruction from the serial front end
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_data,
    input wire logic [23:0] cmd_addr,
    input wire logic [1:0] density_sel,
    // array engine
    input wire logic op_done,
    // pins
    input wire logic wp_n_pin,
    input wire logic hw_rst_n_pin,
    // read answer
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    // status view
    output logic busy_q,
    output logic quad_en_q,
    output logic status_locked_q,
    // operation start to the array engine
    output logic op_start_q,
    output logic [2:0] op_kind_q,
    output logic [23:0] op_addr_q,
    output logic [8:0] op_sector_q,
    output logic [5:0] op_blk32_q,
    output logic [4:0] op_blk64_q,
    output logic suspend_q,
    output logic abort_q
);

    // ------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------
    logic [1:0] pin_raw;
    logic [1:0] pin_lvl_q;
    assign pin_raw = {hw_rst_n_pin, wp_n_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            logic [`FSA_SYNC_LEN-1:0] sh_q;
            // three stages; level moves once stages two and three agree
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    sh_q <= 3'h7;
                    pin_lvl_q[gi] <= 1'b1;
                end else begin
                    sh_q <= {sh_q[1:0], pin_raw[gi]};
                    if (sh_q[1] == sh_q[2]) begin
                        pin_lvl_q[gi] <= sh_q[2];
                    end
                end
            end
        end
    endgenerate

    logic wp_lvl;
    logic hw_rst_act;
    assign wp_lvl = pin_lvl_q[0];
    assign hw_rst_act = ~pin_lvl_q[1];

    // ------------------------------------------------
    // state
    // ------------------------------------------------
    fsa_pkg::fsa_state_e state_q;
    fsa_pkg::fsa_state_e state_d;
    logic reg_protect_bit_q;
    logic quad_pin_enable_q;
    logic [3:0] protect_field_q;
    logic write_enable_latch_q;
    logic [7:0] wr_pend_q;
    logic [7:0] status_word;

    // live status byte, busy taken from the state
    assign status_word = {reg_protect_bit_q, quad_pin_enable_q,
                          protect_field_q, write_enable_latch_q,
                          busy_q};

    // ------------------------------------------------
    // instruction decode
    // ------------------------------------------------
    logic is_stat_rd;
    logic is_rdreg;
    logic is_rst;
    logic is_susp;
    logic is_set_latch;
    logic is_clr_latch;
    logic is_stat_wr;
    logic is_page;
    logic is_sect;
    logic is_b32;
    logic is_b64;
    logic is_chip;
    logic is_nvo;
    assign is_stat_rd = cmd_code == `FSA_STAT_RD;
    assign is_rdreg = (cmd_code == `FSA_RDFR) | (cmd_code == `FSA_RDERP);
    assign is_rst = (cmd_code == `FSA_RST_EN) | (cmd_code == `FSA_RST);
    assign is_susp = (cmd_code == `FSA_SUSP_A) | (cmd_code == `FSA_SUSP_B);
    assign is_set_latch = cmd_code == `FSA_SET_LATCH;
    assign is_clr_latch = cmd_code == `FSA_CLR_LATCH;
    assign is_stat_wr = cmd_code == `FSA_STAT_WR;
    assign is_page = (cmd_code == `FSA_PP) | (cmd_code == `FSA_PPQ_A)
                   | (cmd_code == `FSA_PPQ_B);
    assign is_sect = (cmd_code == `FSA_SER_A) | (cmd_code == `FSA_SER_B);
    assign is_b32 = cmd_code == `FSA_BER32;
    assign is_b64 = cmd_code == `FSA_BER64;
    assign is_chip = (cmd_code == `FSA_ARR_ERASE_A) | (cmd_code == `FSA_ARR_ERASE_B);
    assign is_nvo = (cmd_code == `FSA_WRFR) | (cmd_code == `FSA_SRPNV)
                  | (cmd_code == `FSA_SERPNV) | (cmd_code == `FSA_IRER)
                  | (cmd_code == `FSA_IRP) | (cmd_code == `FSA_WRABR);

    // ------------------------------------------------
    // address map and block protection
    // ------------------------------------------------
    logic [23:0] top_addr;
    logic [23:0] addr_m;
    logic [5:0] nblk;
    logic [5:0] blk6;
    logic [5:0] n_top;
    logic [5:0] n_bot;
    logic bp_top;
    logic bp_bot;
    logic bp_all;
    logic blk_prot;
    // top address shrinks by halves from the largest density
    assign top_addr = `FSA_TOP_MAX >> (`FSA_DENS_MAX - density_sel);
    assign addr_m = cmd_addr & top_addr;
    assign nblk = 6'(`FSA_BLKS_MIN << density_sel);
    assign blk6 = {1'b0, addr_m[`FSA_ADDR_MSB:`FSA_B64_LSB]};
    assign n_top = 6'(6'h01 << (protect_field_q - `FSA_BP_ONE));
    assign n_bot = 6'(6'h01 << (`FSA_BP_BOT_HI - protect_field_q));
    assign bp_top = (protect_field_q >= `FSA_BP_ONE)
                  & (protect_field_q <= `FSA_BP_TOP_END);
    assign bp_bot = (protect_field_q >= `FSA_BP_BOT_LO)
                  & (protect_field_q <= `FSA_BP_BOT_HI);
    // a range as wide as the array protects everything
    assign bp_all = ((protect_field_q >= `FSA_BP_ALL_LO)
                   & (protect_field_q <= `FSA_BP_ALL_HI))
                  | (bp_top & (n_top >= nblk))
                  | (bp_bot & (n_bot >= nblk));
    assign blk_prot = bp_all
                    | (bp_top & (blk6 >= (nblk - n_top)))
                    | (bp_bot & (blk6 < n_bot));

    // ------------------------------------------------
    // acceptance
    // ------------------------------------------------
    logic ready;
    logic busy_ok;
    logic take;
    logic wr_lock;
    logic arr_ok;
    logic go_arr;
    logic go_stat_wr;
    logic go_nvo;
    logic sw_rst;
    logic end_op;
    assign ready = state_q == fsa_pkg::ST_READY;
    assign busy_ok = is_stat_rd | is_rdreg | is_rst | is_susp;
    // anything else is dropped while busy and touches nothing
    assign take = cmd_valid & ~hw_rst_act & (ready | busy_ok);
    assign wr_lock = reg_protect_bit_q & ~wp_lvl;
    assign arr_ok = ((is_page | is_sect | is_b32 | is_b64) & ~blk_prot)
                  | (is_chip & (protect_field_q == `FSA_BP_RST));
    assign go_arr = take & ready & write_enable_latch_q & arr_ok;
    assign go_stat_wr = take & ready & write_enable_latch_q
                      & is_stat_wr & ~wr_lock;
    assign go_nvo = take & ready & write_enable_latch_q & is_nvo;
    assign sw_rst = take & is_rst;
    assign end_op = op_done & ~ready;

    // ------------------------------------------------
    // operation state
    // ------------------------------------------------
    // next state of the internal operation
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fsa_pkg::ST_READY: begin
                if (go_arr | go_nvo) begin
                    state_d = fsa_pkg::ST_ARRAY;
                end else if (go_stat_wr) begin
                    state_d = fsa_pkg::ST_NVW;
                end
            end
            fsa_pkg::ST_ARRAY, fsa_pkg::ST_NVW: begin
                if (end_op | sw_rst | hw_rst_act) begin
                    state_d = fsa_pkg::ST_READY;
                end
            end
        endcase
    end

    // state and busy flag
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= fsa_pkg::ST_READY;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= state_d != fsa_pkg::ST_READY;
        end
    end

    // stored status bits, committed when the cell write completes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_protect_bit_q <= 1'b0;
            quad_pin_enable_q <= 1'b0;
            protect_field_q <= `FSA_BP_RST;
            wr_pend_q <= `FSA_STATUS_RST;
        end else begin
            if (go_stat_wr) begin
                wr_pend_q <= cmd_data;
            end
            if (end_op & (state_q == fsa_pkg::ST_NVW)) begin
                reg_protect_bit_q <= wr_pend_q[`FSA_RP];
                quad_pin_enable_q <= wr_pend_q[`FSA_QUAD];
                protect_field_q <= wr_pend_q[`FSA_BP_HI:`FSA_BP_LO];
            end
        end
    end

    // write-enable latch: set and clear commands, auto clear at op end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            write_enable_latch_q <= 1'b0;
        end else if (end_op | sw_rst | hw_rst_act) begin
            write_enable_latch_q <= 1'b0;
        end else if (take & ready & is_set_latch) begin
            write_enable_latch_q <= 1'b1;
        end else if (take & ready & is_clr_latch) begin
            write_enable_latch_q <= 1'b0;
        end
    end

    // ------------------------------------------------
    // answers and engine controls
    // ------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data_q <= `FSA_STATUS_RST;
            rd_valid_q <= 1'b0;
            suspend_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            rd_valid_q <= take & is_stat_rd;
            if (take & is_stat_rd) begin
                rd_data_q <= status_word;
            end
            suspend_q <= take & is_susp & (state_q == fsa_pkg::ST_ARRAY);
            abort_q <= ~ready & (sw_rst | hw_rst_act);
        end
    end

    // status view for the pin muxing and write guards
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            quad_en_q <= 1'b0;
            status_locked_q <= 1'b0;
        end else begin
            quad_en_q <= quad_pin_enable_q;
            status_locked_q <= reg_protect_bit_q;
        end
    end

    // operation start with decoded sector and block indices
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            op_start_q <= 1'b0;
            op_kind_q <= fsa_pkg::OP_PAGE;
            op_addr_q <= 24'h000000;
            op_sector_q <= 9'h000;
            op_blk32_q <= 6'h00;
            op_blk64_q <= 5'h00;
        end else begin
            op_start_q <= go_arr | go_nvo | go_stat_wr;
            if (go_arr | go_nvo | go_stat_wr) begin
                op_addr_q <= addr_m;
                op_sector_q <= addr_m[`FSA_ADDR_MSB:`FSA_SECT_LSB];
                op_blk32_q <= addr_m[`FSA_ADDR_MSB:`FSA_B32_LSB];
                op_blk64_q <= addr_m[`FSA_ADDR_MSB:`FSA_B64_LSB];
                if (go_stat_wr) begin
                    op_kind_q <= fsa_pkg::OP_STATUS;
                end else if (go_nvo) begin
                    op_kind_q <= fsa_pkg::OP_NV_OTHER;
                end else if (is_chip) begin
                    op_kind_q <= fsa_pkg::OP_CHIP;
                end else if (is_b64) begin
                    op_kind_q <= fsa_pkg::OP_BLK64;
                end else if (is_b32) begin
                    op_kind_q <= fsa_pkg::OP_BLK32;
                end else if (is_sect) begin
                    op_kind_q <= fsa_pkg::OP_SECT;
                end else begin
                    op_kind_q <= fsa_pkg::OP_PAGE;
                end
            end
        end
    end

endmodule

// file: fsa_status_properties.sv
`timescale 1ns/1ns
`include "fsa_defs.svh"
// ----------------------------------------
// status block checker
// ----------------------------------------
module fsa_status_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // instruction side and pins
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_data,
    input wire logic [23:0] cmd_addr,
    input wire logic [1:0] density_sel,
    input wire logic op_done,
    input wire logic wp_n_pin,
    input wire logic hw_rst_n_pin,
    // answers and operation start
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic busy_q,
    input wire logic quad_en_q,
    input wire logic status_locked_q,
    input wire logic op_start_q,
    input wire logic [2:0] op_kind_q,
    input wire logic [23:0] op_addr_q,
    input wire logic [8:0] op_sector_q,
    input wire logic [5:0] op_blk32_q,
    input wire logic [4:0] op_blk64_q,
    input wire logic suspend_q,
    input wire logic abort_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // status reads and busy flag
    read_answer_a: assert property (cmd_valid && cmd_code == `FSA_STAT_RD && hw_rst_n_pin
        |=> rd_valid_q) else $error("status read not answered");
    read_busy_a: assert property (rd_valid_q |-> rd_data_q[0] == $past(busy_q))
        else $error("status byte busy bit wrong");
    busy_start_a: assert property ($rose(busy_q) |-> op_start_q)
        else $error("busy rose without operation");
    busy_drop_a: assert property (busy_q |=> !op_start_q)
        else $error("operation started while busy");
    busy_hold_a: assert property (busy_q && !op_done && !cmd_valid && hw_rst_n_pin
        |=> busy_q) else $error("busy fell without completion");
    busy_clear_a: assert property (busy_q && op_done |=> !busy_q)
        else $error("busy not cleared at completion");
    // operation start, address split, suspend and abort causes
    suspend_cause_a: assert property (suspend_q |-> $past(busy_q && cmd_valid))
        else $error("suspend without running operation");
    start_cause_a: assert property (op_start_q |-> $past(cmd_valid && !busy_q))
        else $error("operation started without instruction");
    addr_split_a: assert property (op_start_q |-> op_sector_q == op_addr_q[20:12]
        && op_blk32_q == op_addr_q[20:15] && op_blk64_q == op_addr_q[20:16])
        else $error("sector or block number wrong");
    top_mask_a: assert property (op_start_q && density_sel == 2'h3
        |-> op_addr_q[23:21] == 3'h0) else $error("address above top");
    abort_cause_a: assert property (abort_q |-> $past(busy_q))
        else $error("abort without running operation");
endmodule
bind fsa_status fsa_status_chk u_fsa_status_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
    .density_sel(density_sel), .op_done(op_done), .wp_n_pin(wp_n_pin),
    .hw_rst_n_pin(hw_rst_n_pin), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .busy_q(busy_q), .quad_en_q(quad_en_q), .status_locked_q(status_locked_q),
    .op_start_q(op_start_q), .op_kind_q(op_kind_q), .op_addr_q(op_addr_q),
    .op_sector_q(op_sector_q), .op_blk32_q(op_blk32_q), .op_blk64_q(op_blk64_q),
    .suspend_q(suspend_q), .abort_q(abort_q));

// file: fsa_ctrl_model.sv
`timescale 1ns/1ns
// controller issuing instructions and array engine reporting completion
module fsa_ctrl_model (
    // clock
    input wire logic sys_clk,
    // instruction and completion
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_data,
    output logic [23:0] cmd_addr,
    output logic op_done
);
    // idle values at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_data = 8'h00;
        cmd_addr = 24'h000000;
        op_done = 1'b0;
    end
    // one instruction for one cycle, fields scrambled once released
    task automatic send(input logic [7:0] c, input logic [7:0] d, input logic [23:0] a);
        @(posedge sys_clk);
        #5;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
        cmd_addr = a;
        @(posedge sys_clk);
        #5;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_data = ~d;
        cmd_addr = ~a;
    endtask
    // completion pulse after a chosen latency, prompt or slow
    task automatic finish_op(input int lat);
        repeat (lat) @(posedge sys_clk);
        #5;
        op_done = 1'b1;
        @(posedge sys_clk);
        #5;
        op_done = 1'b0;
    endtask
endmodule

// file: tb.sv
`timescale 1ns/1ns
`include "fsa_defs.svh"
module tb;
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wp_n_pin = 1'b1;
    logic hw_rst_n_pin = 1'b1;
    logic [1:0] density_sel = 2'h3;
    logic cmd_valid, op_done, rd_valid_q, busy_q, quad_en_q, status_locked_q;
    logic op_start_q, suspend_q;
    logic [7:0] cmd_code, cmd_data, rd_data_q, nv, d;
    logic [23:0] cmd_addr, op_addr_q, a;
    logic [2:0] op_kind_q;
    logic [8:0] op_sector_q;
    logic [5:0] op_blk32_q;
    logic [4:0] op_blk64_q;
    int fails = 0;
    int samples_checked = 0;
    int n_start = 0;
    int n_susp = 0;
    int s0;
    always #25 sys_clk = ~sys_clk;
    // count start and suspend pulses
    always @(posedge sys_clk) begin
        if (op_start_q === 1'b1) n_start++;
        if (suspend_q === 1'b1) n_susp++;
    end
    fsa_ctrl_model u_fsa_ctrl_model (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_addr(cmd_addr), .op_done(op_done));
    fsa_status u_fsa_status (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
        .density_sel(density_sel), .op_done(op_done), .wp_n_pin(wp_n_pin),
        .hw_rst_n_pin(hw_rst_n_pin), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .busy_q(busy_q), .quad_en_q(quad_en_q), .status_locked_q(status_locked_q),
        .op_start_q(op_start_q), .op_kind_q(op_kind_q), .op_addr_q(op_addr_q),
        .op_sector_q(op_sector_q), .op_blk32_q(op_blk32_q), .op_blk64_q(op_blk64_q),
        .suspend_q(suspend_q), .abort_q());
    // expected status byte from stored bits, latch and busy
    function automatic logic [7:0] exp_status(input logic [7:0] s, input logic w, input logic b);
        return {s[7:2], w, b};
    endfunction
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // compare a design value
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare a pulse count
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for read answer or operation start
    task automatic wait_hi(input bit rd);
        int k;
        for (k = 0; k < 6 && (rd ? rd_valid_q : op_start_q) !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        if (k == 6) begin
            fails++;
            conclude();
        end
    endtask
    task automatic send(input logic [7:0] c, input logic [23:0] ad);
        u_fsa_ctrl_model.send(c, d, ad);
    endtask
    task automatic rd_status(input logic [7:0] exp);
        send(`FSA_STAT_RD, 24'h0);
        wait_hi(1'b1);
        chk_val(24'(rd_data_q), 24'(exp));
    endtask
    // completion at random latency, then bounded wait for ready
    task automatic op_end();
        int k;
        u_fsa_ctrl_model.finish_op($urandom_range(12, 0));
        for (k = 0; k < 4 && busy_q !== 1'b0; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk_val(24'(busy_q), 24'h0);
    endtask
    // overall limit against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        conclude();
    end
    // main sequence
    initial begin
        void'($urandom(32241));
        d = 8'h3c;
        repeat (2) @(posedge sys_clk);
        #5;
        sys_rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        nv = 8'h00;
        rd_status(8'h00);
        send(`FSA_STAT_WR, 24'h0);
        rd_status(8'h00);
        send(`FSA_SET_LATCH, 24'h0);
        rd_status(8'h02);
        send(`FSA_CLR_LATCH, 24'h0);
        rd_status(8'h00);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h7f : (i == 3) ? 8'h17 : 8'($urandom) & 8'h7f;
            s0 = n_start;
            send(`FSA_SET_LATCH, 24'h0);
            send(`FSA_STAT_WR, 24'h0);
            wait_hi(1'b0);
            chk_val(24'(op_kind_q), 24'(fsa_pkg::OP_STATUS));
            rd_status(exp_status(nv, 1'b1, 1'b1));
            send(`FSA_SER_B, 24'h0);
            op_end();
            chk_cnt(n_start, s0 + 1);
            nv = {d[7:2], 2'b00};
            rd_status(exp_status(nv, 1'b0, 1'b0));
            chk_val(24'(quad_en_q), 24'(nv[6]));
        end
        a = 24'($urandom) & 24'h0fffff;
        send(`FSA_SET_LATCH, 24'h0);
        send(`FSA_BER64, a);
        wait_hi(1'b0);
        chk_val(24'(op_kind_q), 24'(fsa_pkg::OP_BLK64));
        chk_val(24'(op_blk64_q), 24'(a[20:16]));
        chk_val(24'(op_sector_q), 24'(a[20:12]));
        s0 = n_susp;
        send(`FSA_SUSP_A, 24'h0);
        repeat (3) @(posedge sys_clk);
        chk_cnt(n_susp, s0 + 1);
        op_end();
        rd_status(exp_status(nv, 1'b0, 1'b0));
        s0 = n_start;
        send(`FSA_SET_LATCH, 24'h0);
        send(`FSA_BER64, a | 24'h100000);
        send(`FSA_ARR_ERASE_A, 24'h0);
        repeat (3) @(posedge sys_clk);
        chk_cnt(n_start, s0);
        rd_status(exp_status(nv, 1'b1, 1'b0));
        d = 8'h80;
        send(`FSA_STAT_WR, 24'h0);
        op_end();
        repeat (2) @(posedge sys_clk);
        chk_val(24'(status_locked_q), 24'h1);
        #5;
        wp_n_pin = 1'b0;
        d = 8'h00;
        s0 = n_start;
        repeat (4) @(posedge sys_clk);
        send(`FSA_SET_LATCH, 24'h0);
        send(`FSA_STAT_WR, 24'h0);
        repeat (3) @(posedge sys_clk);
        chk_cnt(n_start, s0);
        rd_status(exp_status(8'h80, 1'b1, 1'b0));
        #5;
        wp_n_pin = 1'b1;
        repeat (4) @(posedge sys_clk);
        send(`FSA_STAT_WR, 24'h0);
        op_end();
        rd_status(8'h00);
        send(`FSA_SET_LATCH, 24'h0);
        send(`FSA_ARR_ERASE_B, 24'h0);
        wait_hi(1'b0);
        chk_val(24'(op_kind_q), 24'(fsa_pkg::OP_CHIP));
        op_end();
        // smallest density wraps addresses at its top
        #5;
        density_sel = 2'h0;
        send(`FSA_SET_LATCH, 24'h0);
        send(`FSA_BER64, 24'h1f0000);
        wait_hi(1'b0);
        chk_val(op_addr_q, 24'h030000);
        chk_val(24'(op_blk64_q), 24'h3);
        op_end();
        conclude();
    end
endmodule
